// ---- bridge_pwm_map.svh ----
// Register map, field positions, reset values and timing figures of the bridge PWM block
`ifndef BRIDGE_PWM_MAP_SVH
`define BRIDGE_PWM_MAP_SVH

// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define OFS_DELAY_RESTART 8'h00
`define OFS_SHUTDOWN 8'h04
`define OFS_BRIDGE_CTRL 8'h08
`define ADDR_LSB 2
`define ADDR_MSB 7

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define RESTART_BIT 7
`define DC_MSB 6
`define SD_STATUS_BIT 7
`define SD_SRC_MSB 6
`define SD_SRC_LSB 4
`define SD_AC_MSB 3
`define SD_AC_LSB 2
`define SD_BD_MSB 1
`define SD_BD_LSB 0
`define CTRL_FULL_BIT 0
`define CTRL_DIR_BIT 1
`define CTRL_DIR_APPLIED_BIT 2
`define CTRL_BLANK_BIT 3
`define CTRL_WR_MSB 1

// ----------------------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------------------
`define DELAY_RESTART_RST 8'h00
`define SHUTDOWN_RST 8'h00
`define CTRL_RST 2'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------------------
// Timing: clock period and oscillator period in ns, leads in oscillator periods
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define TOSC_NS 4
`define INSTR_TOSC 4
`define LEAD_PS1_TOSC 4
`define LEAD_PS4_TOSC 16
`define LEAD_PS16_TOSC 64

`endif

// ---- bridge_pwm_pkg.sv ----
// Types shared by the bridge PWM steering and shutdown block
package bridge_pwm_pkg;

    // One bit per bridge output
    typedef struct packed {
        logic first;
        logic second;
        logic third;
        logic fourth;
    } bridge_s;

    typedef enum logic {
        DIR_FORWARD = 1'b0,
        DIR_REVERSE = 1'b1
    } dir_e;

    typedef enum logic [1:0] {
        PIN_LOW = 2'b00,
        PIN_HIGH = 2'b01,
        PIN_TRI = 2'b10,
        PIN_TRI_ALT = 2'b11
    } pin_state_e;

    typedef logic [15:0] count_t;

endpackage

// ---- bridge_pwm_steering_shutdown.sv ----
// Bridge PWM output steering, dead band and auto-shutdown with an AXI4-Lite register slave
//
// Overview of operation
// R1: Forward full bridge: first output held active, fourth modulated, others inactive.
// R2: Reverse full bridge: third output held active, second modulated, others inactive.
// R3: Full bridge never has more than two outputs active together.
// R4: A new direction takes effect from the following PWM period.
// R5: Before the period ends, blank modulated outputs and swap held outputs early.
// R6: Early swap lead is 4, 16 or 64 oscillator periods per prescale.
// R7: Full bridge applies no dead band, direction changes included.
// R8: Direction bit may be written anytime; effect is deferred.
// R9: Software must lower duty or use fast-off drivers before reversing.
// R10: Half bridge delays only inactive-to-active edges of each output.
// R11: Dead band equals seven-bit count times four oscillator periods.
// R12: An enabled shutdown event moves outputs into their shutdown states.
// R13: Three-bit source select picks comparators and fault pin combinations.
// R14: Low level on the fault input is a shutdown event when selected.
// R15: Shutdown drives outputs to shutdown states without waiting for the period.
// R16: First/third pair shutdown code: 00 low, 01 high, 1x released.
// R17: Second/fourth pair uses the low two bits, same coding.
// R18: Hardware sets shutdown status on an event; outputs stay in shutdown.
// R19: With restart enabled status clears when cause ends; else software clears.
// R20: Status set at period start keeps shutdown whole period; resume next period.
// R21: Software writes to the status bit are ignored while the cause persists.
// R22: Half bridge drives PWM on first output and its complement on second.
// R23: If dead band exceeds the active time the output stays inactive.
// R24: Writing one to the status bit forces shutdown like a hardware event.
// R25: Comparator causes are levels; status cannot clear while they persist.
// R26: Period boundary comes from the base timer reset pulse.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

module bridge_pwm_steering_shutdown (
    // Clock, reset and freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Base timer
    input wire logic period_start,
    input wire logic pwm_raw,
    input wire logic [1:0] timer_prescale_select,
    // Shutdown sources
    input wire logic comparator1,
    input wire logic comparator2,
    input wire logic fault_input_n,
    // Bridge pins
    output bridge_pwm_pkg::bridge_s bridge_out,
    output bridge_pwm_pkg::bridge_s bridge_oe_n
);

    `include "bridge_pwm_map.svh"

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0] delay_restart_q;
    logic [6:0] shutdown_cfg_q;
    logic shutdown_status_q;
    logic full_bridge_q;
    logic direction_select_q;

    logic restart_enable;
    logic [6:0] dead_band_count;
    logic [2:0] shutdown_source_select;
    bridge_pwm_pkg::pin_state_e pair_ac_shutdown_state;
    bridge_pwm_pkg::pin_state_e pair_bd_shutdown_state;

    assign restart_enable = delay_restart_q[`RESTART_BIT];
    assign dead_band_count = delay_restart_q[`DC_MSB:0];
    assign shutdown_source_select = shutdown_cfg_q[`SD_SRC_MSB:`SD_SRC_LSB];
    assign pair_ac_shutdown_state = bridge_pwm_pkg::pin_state_e'(shutdown_cfg_q[`SD_AC_MSB:`SD_AC_LSB]);
    assign pair_bd_shutdown_state = bridge_pwm_pkg::pin_state_e'(shutdown_cfg_q[`SD_BD_MSB:`SD_BD_LSB]);

    // ------------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------------
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic wr_fire;
    logic wr_mapped;
    logic rd_mapped;
    logic [7:0] rd_byte;
    logic [5:0] wr_index;
    logic [5:0] rd_index;

    assign wr_index = awaddr_q[`ADDR_MSB:`ADDR_LSB];
    assign rd_index = s_axi_araddr[`ADDR_MSB:`ADDR_LSB];
    assign wr_fire = clk_en && aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_mapped = (wr_index == `OFS_DELAY_RESTART >> `ADDR_LSB)
        || (wr_index == `OFS_SHUTDOWN >> `ADDR_LSB)
        || (wr_index == `OFS_BRIDGE_CTRL >> `ADDR_LSB);
    assign rd_mapped = (rd_index == `OFS_DELAY_RESTART >> `ADDR_LSB)
        || (rd_index == `OFS_SHUTDOWN >> `ADDR_LSB)
        || (rd_index == `OFS_BRIDGE_CTRL >> `ADDR_LSB);

    // Address and data are taken independently; the response waits for both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Period timing and direction change
    // ------------------------------------------------------------------------
    bridge_pwm_pkg::count_t cnt_q;
    bridge_pwm_pkg::count_t period_len_q;
    bridge_pwm_pkg::count_t lead;
    logic dir_applied_q;
    logic unmod_dir_q;
    logic blank_q;
    logic lead_point;

    // Lead is counted in clocks, derived from oscillator periods
    always_comb begin
        unique case (timer_prescale_select)
            2'h0: lead = 16'(`LEAD_PS1_TOSC * `TOSC_NS / `CLK_PERIOD_NS); // R6
            2'h1: lead = 16'(`LEAD_PS4_TOSC * `TOSC_NS / `CLK_PERIOD_NS); // R6
            default: lead = 16'(`LEAD_PS16_TOSC * `TOSC_NS / `CLK_PERIOD_NS); // R6
        endcase
    end

    // The period length is learnt from the previous period, so the first period after start-up makes no early swap
    assign lead_point = (period_len_q > lead) && (16'(cnt_q + lead) == period_len_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 16'h0000;
            period_len_q <= 16'h0000;
        end else if (clk_en) begin
            if (period_start) begin // R26
                cnt_q <= 16'h0001;
                period_len_q <= cnt_q;
            end else if (cnt_q != 16'hFFFF) begin
                cnt_q <= 16'(cnt_q + 16'h0001);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_applied_q <= bridge_pwm_pkg::DIR_FORWARD;
            unmod_dir_q <= bridge_pwm_pkg::DIR_FORWARD;
            blank_q <= 1'b0;
        end else if (clk_en) begin
            if (period_start) begin
                blank_q <= 1'b0;
                // Outside full bridge a pending change simply lands at the boundary
                dir_applied_q <= full_bridge_q ? unmod_dir_q : direction_select_q; // R4
                unmod_dir_q <= full_bridge_q ? unmod_dir_q : direction_select_q;
            end else if (full_bridge_q && lead_point && (direction_select_q != dir_applied_q)) begin // R8
                blank_q <= 1'b1; // R5
                unmod_dir_q <= direction_select_q; // R5
            end
        end
    end

    // ------------------------------------------------------------------------
    // Half-bridge dead band, one counter per output
    // ------------------------------------------------------------------------
    logic [1:0] hb_raw;
    logic [1:0] hb_active;
    logic [8:0] db_load;

    assign hb_raw = {~pwm_raw, pwm_raw}; // R22
    assign db_load = {dead_band_count, 2'b00}; // R11

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_dead_band
            logic [8:0] db_cnt_q;
            // Falling edges pass at once; rising edges wait for the count
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    db_cnt_q <= 9'h000;
                end else if (clk_en) begin
                    if (!hb_raw[gi]) begin
                        db_cnt_q <= 9'h000; // R10
                    end else if (db_cnt_q != db_load) begin
                        db_cnt_q <= 9'(db_cnt_q + 9'h001);
                    end
                end
            end
            assign hb_active[gi] = hb_raw[gi] && (db_cnt_q == db_load); // R10 R23
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Auto-shutdown
    // ------------------------------------------------------------------------
    logic sd_cause;
    logic sd_hold_q;
    logic sd_wr;
    logic sd_now;

    assign sd_cause = (shutdown_source_select[0] && comparator1) // R13 R25
        || (shutdown_source_select[1] && comparator2) // R13 R25
        || (shutdown_source_select[2] && !fault_input_n); // R13 R14
    assign sd_wr = wr_fire && wstrb0_q && (wr_index == `OFS_SHUTDOWN >> `ADDR_LSB);
    assign sd_now = sd_cause || shutdown_status_q || sd_hold_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shutdown_status_q <= 1'b0;
        end else if (clk_en) begin
            if (sd_cause) begin
                shutdown_status_q <= 1'b1; // R18 R21
            end else if (sd_wr) begin
                shutdown_status_q <= wdata_q[`SD_STATUS_BIT]; // R24
            end else if (restart_enable) begin
                shutdown_status_q <= 1'b0; // R19
            end
        end
    end

    // Holds the pins in shutdown until a period starts with the status clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sd_hold_q <= 1'b0;
        end else if (clk_en) begin
            if (sd_cause || shutdown_status_q) begin
                sd_hold_q <= 1'b1; // R20
            end else if (period_start) begin
                sd_hold_q <= 1'b0; // R20
            end
        end
    end

    // ------------------------------------------------------------------------
    // Configuration writes
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            delay_restart_q <= `DELAY_RESTART_RST;
            shutdown_cfg_q <= 7'(`SHUTDOWN_RST);
            {direction_select_q, full_bridge_q} <= `CTRL_RST;
        end else if (wr_fire && wstrb0_q) begin
            if (wr_index == `OFS_DELAY_RESTART >> `ADDR_LSB) begin
                delay_restart_q <= wdata_q;
            end
            if (wr_index == `OFS_SHUTDOWN >> `ADDR_LSB) begin
                shutdown_cfg_q <= wdata_q[`SD_SRC_MSB:0];
            end
            if (wr_index == `OFS_BRIDGE_CTRL >> `ADDR_LSB) begin
                {direction_select_q, full_bridge_q} <= wdata_q[`CTRL_WR_MSB:0]; // R8
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        if (rd_index == `OFS_DELAY_RESTART >> `ADDR_LSB) begin
            rd_byte = delay_restart_q;
        end else if (rd_index == `OFS_SHUTDOWN >> `ADDR_LSB) begin
            rd_byte = {shutdown_status_q, shutdown_cfg_q};
        end else if (rd_index == `OFS_BRIDGE_CTRL >> `ADDR_LSB) begin
            rd_byte[`CTRL_FULL_BIT] = full_bridge_q;
            rd_byte[`CTRL_DIR_BIT] = direction_select_q;
            rd_byte[`CTRL_DIR_APPLIED_BIT] = dir_applied_q;
            rd_byte[`CTRL_BLANK_BIT] = blank_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Output steering
    // ------------------------------------------------------------------------
    bridge_pwm_pkg::bridge_s out_d;
    bridge_pwm_pkg::bridge_s oe_n_d;

    always_comb begin
        out_d = '0;
        oe_n_d = '0;
        if (sd_now) begin
            unique case (pair_ac_shutdown_state) // R12 R16
                bridge_pwm_pkg::PIN_LOW: out_d.first = 1'b0;
                bridge_pwm_pkg::PIN_HIGH: out_d.first = 1'b1;
                bridge_pwm_pkg::PIN_TRI, bridge_pwm_pkg::PIN_TRI_ALT: oe_n_d.first = 1'b1;
            endcase
            unique case (pair_bd_shutdown_state) // R12 R17
                bridge_pwm_pkg::PIN_LOW: out_d.second = 1'b0;
                bridge_pwm_pkg::PIN_HIGH: out_d.second = 1'b1;
                bridge_pwm_pkg::PIN_TRI, bridge_pwm_pkg::PIN_TRI_ALT: oe_n_d.second = 1'b1;
            endcase
            out_d.third = out_d.first;
            oe_n_d.third = oe_n_d.first;
            out_d.fourth = out_d.second;
            oe_n_d.fourth = oe_n_d.second;
        end else if (full_bridge_q) begin
            // Modulated outputs take the raw PWM with no dead band
            if (unmod_dir_q == bridge_pwm_pkg::DIR_FORWARD) begin
                out_d.first = 1'b1; // R1 R3
                out_d.fourth = pwm_raw && !blank_q; // R1 R5 R7
            end else begin
                out_d.third = 1'b1; // R2 R3
                out_d.second = pwm_raw && !blank_q; // R2 R5 R7
            end
        end else begin
            out_d.first = hb_active[0]; // R22
            out_d.second = hb_active[1]; // R22
        end
    end

    // Pins are registered, so a shutdown reaches them one clock after its cause
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bridge_out <= '0;
            bridge_oe_n <= '1;
        end else if (clk_en) begin
            bridge_out <= out_d; // R15
            bridge_oe_n <= oe_n_d;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_two_active_max: assert property (full_bridge_q && !sd_now |-> $countones(out_d) <= 2) // R3
        else $error("more than two bridge outputs active");

    a_forward_drive: assert property (clk_en && full_bridge_q && !sd_now && !blank_q
        && unmod_dir_q == bridge_pwm_pkg::DIR_FORWARD
        |=> bridge_out.first && !bridge_out.second && !bridge_out.third
        && bridge_out.fourth == $past(pwm_raw)) // R1
        else $error("forward drive pattern wrong");

    a_reverse_drive: assert property (clk_en && full_bridge_q && !sd_now && !blank_q
        && unmod_dir_q == bridge_pwm_pkg::DIR_REVERSE
        |=> !bridge_out.first && !bridge_out.fourth && bridge_out.third
        && bridge_out.second == $past(pwm_raw)) // R2
        else $error("reverse drive pattern wrong");

    a_blank_mod_off: assert property (blank_q && !sd_now |-> !out_d.second && !out_d.fourth) // R5
        else $error("modulated output active during blanking");

    a_dir_deferred: assert property ($changed(dir_applied_q) |-> $past(period_start && clk_en)) // R4
        else $error("direction changed away from a period boundary");

    a_swap_lead: assert property ($rose(blank_q) |-> 16'($past(cnt_q) + $past(lead)) == $past(period_len_q)) // R6
        else $error("early swap not at the lead point");

    a_sd_sets_status: assert property (clk_en && sd_cause |=> shutdown_status_q ##1 sd_hold_q) // R18
        else $error("shutdown event did not set status");

    a_sd_no_clear: assert property (clk_en && sd_cause && shutdown_status_q |=> shutdown_status_q) // R21
        else $error("status cleared while cause active");

    a_restart_clear: assert property (clk_en && restart_enable && shutdown_status_q && !sd_cause && !sd_wr
        |=> !shutdown_status_q) // R19
        else $error("auto restart did not clear status");

    a_hold_period: assert property (clk_en && sd_hold_q && !period_start |=> sd_hold_q) // R20
        else $error("shutdown released before a period boundary");

    a_sd_pins_low: assert property (clk_en && sd_now && pair_ac_shutdown_state == bridge_pwm_pkg::PIN_LOW
        |=> !bridge_out.first && !bridge_out.third && !bridge_oe_n.first) // R16
        else $error("pair shutdown low not driven");

    a_sd_pins_tri: assert property (clk_en && sd_now && shutdown_cfg_q[`SD_BD_MSB]
        |=> bridge_oe_n.second && bridge_oe_n.fourth) // R17
        else $error("pair shutdown release not applied");

    a_dead_band_wait: assert property (clk_en && !full_bridge_q && !sd_now && $rose(pwm_raw) && dead_band_count != 7'h00
        |-> !out_d.first ##1 !out_d.first) // R10 R11
        else $error("half bridge rising edge not delayed");

endmodule

// ---- bridge_far_model.sv ----
// Far-side model: base timer with a 64-clock PWM period and duty level
`timescale 1ns/1ps
module bridge_far_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Duty in clocks
    input wire logic [5:0] duty,
    // Timer outputs
    output logic period_start,
    output logic pwm_raw,
    output logic [5:0] phase
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 6'h00;
            period_start <= 1'h0;
            pwm_raw <= 1'h0;
        end else begin
            phase <= phase + 6'h01;
            period_start <= (phase == 6'h3F);
            pwm_raw <= (phase + 6'h01) < duty;
        end
    end
endmodule

// ---- bridge_pwm_steering_shutdown_tb.sv ----
// Self-checking bench for the bridge PWM steering and shutdown block
`timescale 1ns/1ps
module bridge_pwm_steering_shutdown_tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic fault_n = 1'h1, cmp1 = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, period_start, pwm_raw;
    logic [1:0] bresp, rresp;
    logic [5:0] duty = 6'h20;
    logic [1:0] presc = 2'h0;
    logic [5:0] phase;
    bridge_pwm_pkg::bridge_s bout, boe_n;
    int mismatches = 0, n_tests = 0;
    initial begin
        forever #2 aclk = ~aclk;
    end
    bridge_far_model far_u (.aclk(aclk), .aresetn(aresetn), .duty(duty), .period_start(period_start),
        .pwm_raw(pwm_raw), .phase(phase));
    bridge_pwm_steering_shutdown dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(1'h1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .period_start(period_start), .pwm_raw(pwm_raw), .timer_prescale_select(presc),
        .comparator1(cmp1), .comparator2(1'h0), .fault_input_n(fault_n),
        .bridge_out(bout), .bridge_oe_n(boe_n));
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task hung;
        mismatches++;
        give_verdict();
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits on the timer phase so pin checks sit in settled parts of the period
    task at(input logic [5:0] p);
        for (int i = 0; i < 300; i++) begin
            @(posedge aclk);
            if (phase === p) return;
        end
        hung();
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) begin
                bready <= 1'h0;
                chk({30'h0, bresp}, 32'h0);
                return;
            end
        end
        hung();
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) begin
                rready <= 1'h0;
                chk(rdata, {24'h0, exp});
                chk({30'h0, rresp}, {30'h0, er});
                return;
            end
        end
        hung();
    endtask
    task sc_regs;
        rd(8'h00, 8'h00, 2'h0);
        rd(8'h04, 8'h00, 2'h0);
        rd(8'h0C, 8'h00, 2'h2);
    endtask
    task sc_full;
        wr(8'h08, 8'h01);
        at(10);
        chk({28'h0, bout}, 32'h9);
        at(40);
        chk({28'h0, bout}, 32'h8);
        duty <= 6'h10;
        presc <= 2'h1;
        wr(8'h08, 8'h03);
        at(45);
        chk({28'h0, bout}, 32'h8);
        at(50);
        chk({28'h0, bout}, 32'h2);
        at(62);
        chk({28'h0, bout}, 32'h2);
        at(5);
        chk({28'h0, bout}, 32'h6);
        at(30);
        chk({28'h0, bout}, 32'h2);
    endtask
    task sc_half;
        duty <= 6'h20;
        wr(8'h08, 8'h00);
        wr(8'h00, 8'h03);
        at(10);
        chk({28'h0, bout}, 32'h0);
        at(17);
        chk({28'h0, bout}, 32'h8);
        at(38);
        chk({28'h0, bout}, 32'h0);
        at(52);
        chk({28'h0, bout}, 32'h4);
        wr(8'h00, 8'h7F);
        at(20);
        chk({28'h0, bout}, 32'h0);
        wr(8'h00, 8'h03);
    endtask
    task sc_shut;
        wr(8'h04, 8'h46);
        fault_n <= 1'h0;
        rd(8'h04, 8'hC6, 2'h0);
        chk({30'h0, bout.first, bout.third}, 32'h3);
        chk({28'h0, boe_n}, 32'h5);
        wr(8'h04, 8'h46);
        rd(8'h04, 8'hC6, 2'h0);
        fault_n <= 1'h1;
        at(40);
        rd(8'h04, 8'hC6, 2'h0);
        wr(8'h04, 8'h46);
        rd(8'h04, 8'h46, 2'h0);
        chk({28'h0, boe_n}, 32'h5);
        at(20);
        chk({28'h0, bout}, 32'h8);
        wr(8'h00, 8'h83);
        wr(8'h04, 8'h16);
        cmp1 <= 1'h1;
        wr(8'h04, 8'h16);
        rd(8'h04, 8'h96, 2'h0);
        cmp1 <= 1'h0;
        rd(8'h04, 8'h16, 2'h0);
        wr(8'h00, 8'h03);
        wr(8'h04, 8'h86);
        rd(8'h04, 8'h86, 2'h0);
        chk({28'h0, boe_n}, 32'h5);
        wr(8'h04, 8'h82);
        rd(8'h04, 8'h82, 2'h0);
        chk({28'h0, bout}, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        sc_regs();
        sc_full();
        sc_half();
        sc_shut();
        give_verdict();
    end
endmodule
